// >>> hdl/kcsr_pkg.sv
package kcsr_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_ARG0 = 12'h004;
  localparam logic [11:0] ADDR_ARG1 = 12'h008;
  localparam logic [11:0] ADDR_ARG2 = 12'h00C;
  localparam logic [11:0] ADDR_ARG3 = 12'h010;
  localparam logic [11:0] ADDR_ARG4 = 12'h014;
  localparam logic [11:0] ADDR_ARG5 = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01C;
  localparam logic [11:0] ADDR_EN_PRI = 12'h020;
  localparam logic [11:0] ADDR_ST_PRI = 12'h024;
  localparam logic [11:0] ADDR_EN_SEC = 12'h028;
  localparam logic [11:0] ADDR_ST_SEC = 12'h02C;
  localparam logic [11:0] ADDR_EN_XIO = 12'h030;
  localparam logic [11:0] ADDR_ST_XIO = 12'h034;
  localparam logic [11:0] ADDR_RECOV = 12'h038;
  localparam logic [11:0] ADDR_ACK = 12'h03C;

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_KILL_MASK = 8'hA7;
  localparam logic [7:0] CMD_KILL_RECOVERY = 8'hB5;
  localparam logic [7:0] CMD_KEEP_DRIVER = 8'hB6;
  localparam logic [7:0] CMD_DROP_DRIVER = 8'hB7;
  localparam logic [7:0] CMD_KILL_MASK_EXT = 8'hDC;
  localparam logic [7:0] CMD_MULTITASK_EN = 8'h94;
  localparam logic [7:0] CMD_MULTITASK_DIS = 8'h93;
  localparam logic [7:0] CMD_DRIVER_EN = 8'hE3;

  // ------------------------------------------------------------
  // reset values and special recovery values
  // ------------------------------------------------------------
  localparam logic [15:0] EN_PRI_RST = 16'h0080;
  localparam logic [15:0] ST_PRI_RST = 16'h0000;
  localparam logic [15:0] RECOV_IDLE = 16'h0000;
  localparam logic [15:0] RECOV_NV0 = 16'hFFFF;
  localparam logic [15:0] NV_ADDR_ZERO = 16'h0000;

  // status register bit positions
  localparam int ST_SHUT = 0;
  localparam int ST_DRV = 1;
  localparam int ST_KEEP = 2;
  localparam int ST_MT = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_RUN = 5;

  typedef enum logic [1:0] {
    KCSR_NORMAL = 2'b00,
    KCSR_SHUT = 2'b01,
    KCSR_START = 2'b10,
    KCSR_IDLE = 2'b11
  } kcsr_state_t;
endpackage : kcsr_pkg

// >>> hdl/kcsr_eval_if.sv
interface kcsr_eval_if;
  logic [15:0] word_pri;
  logic [15:0] word_sec;
  logic [15:0] word_xio;
  logic [15:0] en_pri;
  logic [15:0] st_pri;
  logic [15:0] en_sec;
  logic [15:0] st_sec;
  logic [15:0] en_xio;
  logic [15:0] st_xio;
  logic kill;
  modport ctrl (output word_pri, word_sec, word_xio, en_pri, st_pri, en_sec, st_sec, en_xio, st_xio,
                input kill);
  modport eval (input word_pri, word_sec, word_xio, en_pri, st_pri, en_sec, st_sec, en_xio, st_xio,
                output kill);
endinterface : kcsr_eval_if

// >>> hdl/kcsr_eval.sv
module kcsr_eval (
  kcsr_eval_if.eval ev // masks, patterns, words and verdict
);
  function automatic logic kcsr_match(input logic [15:0] w, input logic [15:0] en, input logic [15:0] st);
    kcsr_match = |(en & ~(w ^ st));
  endfunction : kcsr_match

  assign ev.kill = kcsr_match(ev.word_pri, ev.en_pri, ev.st_pri)
                 | kcsr_match(ev.word_sec, ev.en_sec, ev.st_sec)
                 | kcsr_match(ev.word_xio, ev.en_xio, ev.st_xio);
endmodule : kcsr_eval

// >>> hdl/kcsr_top.sv
// Summary of operation
// - command 182 keeps the driver enabled when a kill condition occurs and the recovery value is not 0.
// - keeping the driver enabled works only while multitasking is enabled.
// - default kill disables the driver and stops motion at once.
// - after a kill drop the driver stays off until a driver-enable command.
// - a status bit is evaluated only where its enable mask bit is 1.
// - a status bit with enable mask bit 0 is ignored.
// - command 167 loads primary mask and pattern; any enabled match kills.
// - command 220 loads mask and pattern for primary, secondary, extended words.
// - over-voltage always kills while driver is on and always drops the driver.
// - after reset only over-temperature, primary bit 7, is enabled.
// - over-temperature bit is active low, 0 means hot.
// - recovery 0 aborts motion, goes idle, drops driver, no current.
// - recovery -1 runs the program at non-volatile address zero.
// - command 181 loads signed recovery value; other values are program addresses.
//
// Local design decisions: the APB interface to the registers and the register offsets.
module kcsr_top (
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic srst_i, // synchronous reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [11:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic [15:0] primary_status_word_i, // primary status word
  input wire logic [15:0] secondary_status_word_i, // secondary status word
  input wire logic [15:0] extended_io_word_i, // extended io word
  input wire logic over_voltage_i, // over-voltage, active high
  output logic driver_enable_o, // motor driver enable
  output logic motion_abort_o, // one-cycle pulse: stop motion now
  output logic program_start_o, // one-cycle pulse: load and run program
  output logic [15:0] program_addr_o, // non-volatile program address
  output logic idle_o // recovery idle, no motor current
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // kill masks and patterns, changed only by commands
  logic [15:0] en_pri_q;
  logic [15:0] en_pri_d;
  logic [15:0] st_pri_q;
  logic [15:0] st_pri_d;
  logic [15:0] en_sec_q;
  logic [15:0] en_sec_d;
  logic [15:0] st_sec_q;
  logic [15:0] st_sec_d;
  logic [15:0] en_xio_q;
  logic [15:0] en_xio_d;
  logic [15:0] st_xio_q;
  logic [15:0] st_xio_d;
  logic [15:0] recov_q;
  logic [15:0] recov_d;
  logic [15:0] arg_q [6];
  logic [15:0] arg_d [6];
  logic keep_q;
  logic keep_d;
  logic mt_q;
  logic mt_d;
  logic drv_q;
  logic drv_d;
  // one-cycle pulses towards the motion side
  logic abort_q;
  logic abort_d;
  logic start_q;
  logic start_d;
  logic [15:0] paddr_out_q;
  logic [15:0] paddr_out_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic ack_q;
  logic ack_d;
  kcsr_pkg::kcsr_state_t state_q;
  kcsr_pkg::kcsr_state_t state_d;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic cmd_wr;
  logic kill;
  logic ov_kill;
  logic [7:0] cmd;

  kcsr_eval_if ev ();
  assign ev.word_pri = primary_status_word_i;
  assign ev.word_sec = secondary_status_word_i;
  assign ev.word_xio = extended_io_word_i;
  assign ev.en_pri = en_pri_q;
  assign ev.st_pri = st_pri_q;
  assign ev.en_sec = en_sec_q;
  assign ev.st_sec = st_sec_q;
  assign ev.en_xio = en_xio_q;
  assign ev.st_xio = st_xio_q;

  kcsr_eval u_eval (
    .ev(ev)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign pready_o = 1'b1;
  assign wr_en = psel_i & penable_i & pwrite_i;
  // read data captured in the setup cycle so it stands at the access edge
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign cmd_wr = wr_en & (paddr_i == kcsr_pkg::ADDR_CMD);
  assign cmd = pwdata_i[7:0];
  assign ov_kill = over_voltage_i & drv_q;
  assign kill = ev.kill | ov_kill;

  always_comb begin
    case (paddr_i)
      kcsr_pkg::ADDR_CMD, kcsr_pkg::ADDR_ARG0, kcsr_pkg::ADDR_ARG1, kcsr_pkg::ADDR_ARG2,
      kcsr_pkg::ADDR_ARG3, kcsr_pkg::ADDR_ARG4, kcsr_pkg::ADDR_ARG5, kcsr_pkg::ADDR_STATUS,
      kcsr_pkg::ADDR_EN_PRI, kcsr_pkg::ADDR_ST_PRI, kcsr_pkg::ADDR_EN_SEC, kcsr_pkg::ADDR_ST_SEC,
      kcsr_pkg::ADDR_EN_XIO, kcsr_pkg::ADDR_ST_XIO, kcsr_pkg::ADDR_RECOV, kcsr_pkg::ADDR_ACK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ------------------------------------------------------------
  // command execution and register file
  // ------------------------------------------------------------
  always_comb begin
    en_pri_d = en_pri_q;
    st_pri_d = st_pri_q;
    en_sec_d = en_sec_q;
    st_sec_d = st_sec_q;
    en_xio_d = en_xio_q;
    st_xio_d = st_xio_q;
    recov_d = recov_q;
    keep_d = keep_q;
    mt_d = mt_q;
    arg_d = arg_q;
    ack_d = ack_q;
    for (int i = 0; i < 6; i++) begin
      if (wr_en && paddr_i == kcsr_pkg::ADDR_ARG0 + 12'(4 * i)) begin
        arg_d[i] = pwdata_i[15:0];
      end
    end
    if (cmd_wr) begin
      ack_d = 1'b1;
      case (cmd)
        kcsr_pkg::CMD_KEEP_DRIVER: keep_d = 1'b1;
        kcsr_pkg::CMD_DROP_DRIVER: keep_d = 1'b0;
        kcsr_pkg::CMD_MULTITASK_EN: mt_d = 1'b1;
        kcsr_pkg::CMD_MULTITASK_DIS: mt_d = 1'b0;
        kcsr_pkg::CMD_KILL_MASK: begin
          en_pri_d = arg_q[0];
          st_pri_d = arg_q[1];
        end
        kcsr_pkg::CMD_KILL_MASK_EXT: begin
          en_pri_d = arg_q[0];
          st_pri_d = arg_q[1];
          en_sec_d = arg_q[2];
          st_sec_d = arg_q[3];
          en_xio_d = arg_q[4];
          st_xio_d = arg_q[5];
        end
        kcsr_pkg::CMD_KILL_RECOVERY: recov_d = arg_q[0];
        kcsr_pkg::CMD_DRIVER_EN: ;
        default: ack_d = 1'b0;
      endcase
    end else if (wr_en && paddr_i == kcsr_pkg::ADDR_ACK) begin
      ack_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // shutdown and recovery sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    drv_d = drv_q;
    abort_d = 1'b0;
    start_d = 1'b0;
    paddr_out_d = paddr_out_q;
    if (cmd_wr && cmd == kcsr_pkg::CMD_DRIVER_EN) begin
      drv_d = 1'b1;
    end
    case (state_q)
      kcsr_pkg::KCSR_NORMAL, kcsr_pkg::KCSR_IDLE, kcsr_pkg::KCSR_START: begin
        if (kill) begin
          state_d = kcsr_pkg::KCSR_SHUT;
          abort_d = 1'b1;
          if (ov_kill || !(keep_q && mt_q)) begin
            drv_d = 1'b0;
          end
        end else if (state_q == kcsr_pkg::KCSR_START) begin
          state_d = kcsr_pkg::KCSR_NORMAL;
        end else if (state_q == kcsr_pkg::KCSR_IDLE && drv_d) begin
          state_d = kcsr_pkg::KCSR_NORMAL;
        end
      end
      kcsr_pkg::KCSR_SHUT: begin
        if (recov_q == kcsr_pkg::RECOV_IDLE) begin
          state_d = kcsr_pkg::KCSR_IDLE;
          drv_d = 1'b0;
        end else begin
          state_d = kcsr_pkg::KCSR_START;
          start_d = 1'b1;
          paddr_out_d = (recov_q == kcsr_pkg::RECOV_NV0) ? kcsr_pkg::NV_ADDR_ZERO : recov_q;
        end
      end
      default: state_d = kcsr_pkg::KCSR_NORMAL;
    endcase
    // over-voltage drops the driver in every state, shutdown included
    if (ov_kill) begin
      drv_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    if (rd_en) begin
      prdata_d = 32'h0000_0000;
      case (paddr_i)
        kcsr_pkg::ADDR_ARG0: prdata_d[15:0] = arg_q[0];
        kcsr_pkg::ADDR_ARG1: prdata_d[15:0] = arg_q[1];
        kcsr_pkg::ADDR_ARG2: prdata_d[15:0] = arg_q[2];
        kcsr_pkg::ADDR_ARG3: prdata_d[15:0] = arg_q[3];
        kcsr_pkg::ADDR_ARG4: prdata_d[15:0] = arg_q[4];
        kcsr_pkg::ADDR_ARG5: prdata_d[15:0] = arg_q[5];
        kcsr_pkg::ADDR_STATUS: begin
          prdata_d[kcsr_pkg::ST_SHUT] = (state_q == kcsr_pkg::KCSR_SHUT);
          prdata_d[kcsr_pkg::ST_DRV] = drv_q;
          prdata_d[kcsr_pkg::ST_KEEP] = keep_q;
          prdata_d[kcsr_pkg::ST_MT] = mt_q;
          prdata_d[kcsr_pkg::ST_IDLE] = (state_q == kcsr_pkg::KCSR_IDLE);
          prdata_d[kcsr_pkg::ST_RUN] = (state_q == kcsr_pkg::KCSR_START);
        end
        kcsr_pkg::ADDR_EN_PRI: prdata_d[15:0] = en_pri_q;
        kcsr_pkg::ADDR_ST_PRI: prdata_d[15:0] = st_pri_q;
        kcsr_pkg::ADDR_EN_SEC: prdata_d[15:0] = en_sec_q;
        kcsr_pkg::ADDR_ST_SEC: prdata_d[15:0] = st_sec_q;
        kcsr_pkg::ADDR_EN_XIO: prdata_d[15:0] = en_xio_q;
        kcsr_pkg::ADDR_ST_XIO: prdata_d[15:0] = st_xio_q;
        kcsr_pkg::ADDR_RECOV: prdata_d[15:0] = recov_q;
        kcsr_pkg::ADDR_ACK: prdata_d[0] = ack_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      en_pri_q <= kcsr_pkg::EN_PRI_RST;
      st_pri_q <= kcsr_pkg::ST_PRI_RST;
      en_sec_q <= 16'h0000;
      st_sec_q <= 16'h0000;
      en_xio_q <= 16'h0000;
      st_xio_q <= 16'h0000;
      recov_q <= kcsr_pkg::RECOV_IDLE;
      keep_q <= 1'b0;
      mt_q <= 1'b0;
      drv_q <= 1'b0;
      abort_q <= 1'b0;
      start_q <= 1'b0;
      paddr_out_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      state_q <= kcsr_pkg::KCSR_NORMAL;
      for (int i = 0; i < 6; i++) begin
        arg_q[i] <= 16'h0000;
      end
    end else begin
      en_pri_q <= en_pri_d;
      st_pri_q <= st_pri_d;
      en_sec_q <= en_sec_d;
      st_sec_q <= st_sec_d;
      en_xio_q <= en_xio_d;
      st_xio_q <= st_xio_d;
      recov_q <= recov_d;
      keep_q <= keep_d;
      mt_q <= mt_d;
      drv_q <= drv_d;
      abort_q <= abort_d;
      start_q <= start_d;
      paddr_out_q <= paddr_out_d;
      prdata_q <= prdata_d;
      ack_q <= ack_d;
      state_q <= state_d;
      arg_q <= arg_d;
    end
  end

  assign prdata_o = prdata_q;
  assign driver_enable_o = drv_q;
  assign motion_abort_o = abort_q;
  assign program_start_o = start_q;
  assign program_addr_o = paddr_out_q;
  assign idle_o = (state_q == kcsr_pkg::KCSR_IDLE);
endmodule : kcsr_top

// >>> testbench/kcsr_properties.sv
module kcsr_properties (
  input wire logic sys_clk_i, // clock
  input wire logic srst_i, // sync reset
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [11:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic over_voltage_i, // over-voltage
  input wire logic driver_enable_o, // driver enable
  input wire logic motion_abort_o, // abort pulse
  input wire logic program_start_o, // start pulse
  input wire logic idle_o // idle level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic drv_cmd;
  assign drv_cmd = psel_i && penable_i && pwrite_i && paddr_i == kcsr_pkg::ADDR_CMD
                   && pwdata_i[7:0] == kcsr_pkg::CMD_DRIVER_EN;
  a_ready_high: assert property (pready_o)
    else $error("ready low");
  a_slverr_unmapped: assert property (psel_i && penable_i && paddr_i >= 12'h040 |-> pslverr_o)
    else $error("unmapped access not refused");
  a_abort_single: assert property (motion_abort_o |=> !motion_abort_o)
    else $error("abort pulse too long");
  a_abort_then_act: assert property (motion_abort_o |=> idle_o || program_start_o)
    else $error("no recovery action after abort");
  a_start_single: assert property (program_start_o |=> !program_start_o)
    else $error("start pulse too long");
  a_ov_drop: assert property (driver_enable_o && over_voltage_i |=> !driver_enable_o)
    else $error("driver kept on under over-voltage");
  a_idle_no_drive: assert property (idle_o |-> !driver_enable_o)
    else $error("driver on while idle");
  a_drv_rise_cause: assert property ($rose(driver_enable_o) |-> $past(drv_cmd) || $past(drv_cmd, 2))
    else $error("driver enabled without command");
endmodule : kcsr_properties

bind kcsr_top kcsr_properties u_props (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .over_voltage_i, .driver_enable_o, .motion_abort_o, .program_start_o,
  .idle_o);

// >>> testbench/kcsr_host.sv
module kcsr_host (
  input wire logic sys_clk_i, // clock
  input wire logic pready_i, // slave ready
  input wire logic [31:0] prdata_i, // read data
  output logic psel_o, // select
  output logic penable_o, // enable
  output logic pwrite_o, // direction
  output logic [11:0] paddr_o, // address
  output logic [31:0] pwdata_o // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h00000000;
  end
  // one apb transfer; read data taken at the access edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    do @(posedge sys_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask : xfer
endmodule : kcsr_host

// >>> testbench/test_kill_condition_shutdown_recovery.sv
module test_kill_condition_shutdown_recovery;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic over_voltage_i = 1'b0;
  logic [15:0] primary_status_word_i = 16'h0090;
  logic [15:0] secondary_status_word_i = 16'h0000;
  logic [15:0] extended_io_word_i = 16'h0001;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, driver_enable_o, motion_abort_o, program_start_o, idle_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdv;
  logic [15:0] program_addr_o, last_addr;
  logic [15:0] rv [2] = '{16'hFFFF, 16'h021E};
  logic [15:0] ra [2] = '{16'h0000, 16'h021E};
  logic [15:0] xv [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h8000, 16'h0001, 16'h0000};
  int num_errors = 0, check_count = 0, n_abort = 0, n_start = 0, base;
  // scaled-down pause of the host recovery program before it re-enables the driver
  localparam int RECOV_WAIT = 100;
  always #5 sys_clk_i = ~sys_clk_i;
  kcsr_top DUT (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .primary_status_word_i, .secondary_status_word_i, .extended_io_word_i, .over_voltage_i,
    .driver_enable_o, .motion_abort_o, .program_start_o, .program_addr_o, .idle_o);
  kcsr_host host (.sys_clk_i(sys_clk_i), .pready_i(pready_o), .prdata_i(prdata_o), .psel_o(psel_i),
    .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  always @(posedge sys_clk_i) begin
    if (motion_abort_o === 1'b1) n_abort++;
    if (program_start_o === 1'b1) begin
      n_start++;
      last_addr = program_addr_o;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdv);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h00000000, rdv);
    chk(rdv, exp);
  endtask : rdc
  task automatic cmd(input logic [7:0] c);
    wr(kcsr_pkg::ADDR_CMD, {24'h000000, c});
  endtask : cmd
  // status words hold a fault for one cycle, then return to safe levels
  task automatic kick(input logic [15:0] p, input logic [15:0] s, input logic [15:0] x, input logic o);
    primary_status_word_i <= p;
    secondary_status_word_i <= s;
    extended_io_word_i <= x;
    over_voltage_i <= o;
    @(posedge sys_clk_i);
    primary_status_word_i <= 16'h0090;
    secondary_status_word_i <= 16'h0000;
    extended_io_word_i <= 16'h0001;
    over_voltage_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : kick
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    rdc(kcsr_pkg::ADDR_EN_PRI, 32'h00000080);
    rdc(kcsr_pkg::ADDR_ST_PRI, 32'h00000000);
    rdc(12'h040, 32'h00000000);
    kick(16'h0010, 16'h0000, 16'h0001, 1'b0);
    chk(32'(n_abort), 32'h1);
    chk(32'(idle_o), 32'h1);
    repeat (10) @(posedge sys_clk_i);
    chk(32'(driver_enable_o), 32'h0);
    cmd(kcsr_pkg::CMD_DRIVER_EN);
    chk(32'(driver_enable_o), 32'h1);
    rdc(kcsr_pkg::ADDR_STATUS, 32'h00000002);
    rdc(kcsr_pkg::ADDR_ACK, 32'h00000001);
    wr(kcsr_pkg::ADDR_ACK, 32'h00000000);
    rdc(kcsr_pkg::ADDR_ACK, 32'h00000000);
    $display("default kill test done");
    wr(kcsr_pkg::ADDR_ARG0, 32'h00000190);
    wr(kcsr_pkg::ADDR_ARG1, 32'h00000100);
    cmd(kcsr_pkg::CMD_KILL_MASK);
    rdc(kcsr_pkg::ADDR_EN_PRI, 32'h00000190);
    rdc(kcsr_pkg::ADDR_ST_PRI, 32'h00000100);
    kick(16'hFEFF, 16'hFFFF, 16'h0000, 1'b0);
    chk(32'(n_abort), 32'h1);
    kick(16'h0190, 16'h0000, 16'h0001, 1'b0);
    chk(32'(n_abort), 32'h2);
    chk(32'(driver_enable_o), 32'h0);
    $display("mask test done");
    for (int i = 0; i < 2; i++) begin
      wr(kcsr_pkg::ADDR_ARG0, {16'h0000, rv[i]});
      cmd(kcsr_pkg::CMD_KILL_RECOVERY);
      kick(16'h0190, 16'h0000, 16'h0001, 1'b0);
      chk({16'h0000, last_addr}, {16'h0000, ra[i]});
      chk(32'(n_start), 32'(i + 1));
      repeat (RECOV_WAIT) @(posedge sys_clk_i);
      cmd(kcsr_pkg::CMD_DRIVER_EN);
      chk(32'(driver_enable_o), 32'h1);
    end
    $display("recovery test done");
    cmd(kcsr_pkg::CMD_MULTITASK_DIS);
    cmd(kcsr_pkg::CMD_DRIVER_EN);
    cmd(kcsr_pkg::CMD_KEEP_DRIVER);
    kick(16'h0190, 16'h0000, 16'h0001, 1'b0);
    chk(32'(driver_enable_o), 32'h0);
    cmd(kcsr_pkg::CMD_MULTITASK_EN);
    cmd(kcsr_pkg::CMD_DRIVER_EN);
    kick(16'h0190, 16'h0000, 16'h0001, 1'b0);
    chk(32'(driver_enable_o), 32'h1);
    kick(16'h0090, 16'h0000, 16'h0001, 1'b1);
    chk(32'(driver_enable_o), 32'h0);
    cmd(kcsr_pkg::CMD_DRIVER_EN);
    cmd(kcsr_pkg::CMD_DROP_DRIVER);
    kick(16'h0190, 16'h0000, 16'h0001, 1'b0);
    chk(32'(driver_enable_o), 32'h0);
    $display("driver keep test done");
    for (int i = 0; i < 6; i++) wr(kcsr_pkg::ADDR_ARG0 + 12'(4 * i), {16'h0000, xv[i]});
    cmd(kcsr_pkg::CMD_KILL_MASK_EXT);
    rdc(kcsr_pkg::ADDR_EN_SEC, 32'h00008000);
    rdc(kcsr_pkg::ADDR_EN_XIO, 32'h00000001);
    base = n_abort;
    kick(16'h0000, 16'h0000, 16'h0001, 1'b0);
    chk(32'(n_abort), 32'(base));
    kick(16'h0090, 16'h8000, 16'h0001, 1'b0);
    kick(16'h0090, 16'h0000, 16'h0000, 1'b0);
    chk(32'(n_abort), 32'(base + 2));
    $display("extended mask test done");
    complete_run();
  end
endmodule : test_kill_condition_shutdown_recovery
